// file: dv/lcd_host_bus_port_sva.sv
// Pin checker for the LCD host bus, both ends at once.
// Assumes host pins move on clk and device drive on link_clk.
`timescale 1ns/100ps
module lcd_host_bus_port_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic link_clk,
    input wire logic initialize_n,
    input wire logic ps,
    input wire logic style,
    input wire logic chip_select_low,
    input wire logic chip_select_high,
    input wire logic rd_e,
    input wire logic wr_rw,
    input wire logic [7:0] d_line,
    input wire logic [7:0] dev_d_oe
);
    logic sel;
    logic [3:0] desel_cnt_ff;
    logic [3:0] nxt_desel_cnt;

    // Deselect run length; raw pins, so sync lag must be allowed for
    assign sel = !chip_select_low && chip_select_high;
    assign nxt_desel_cnt = sel ? 4'h0 :
        (desel_cnt_ff == 4'hf) ? 4'hf : desel_cnt_ff + 4'h1;
    always_ff @(posedge link_clk or negedge initialize_n)
    begin
        if (!initialize_n)
            desel_cnt_ff <= 4'h0;
        else
            desel_cnt_ff <= nxt_desel_cnt;
    end

    a_serial_no_drive:
        assert property (@(posedge link_clk) disable iff (!initialize_n)
        !ps && !$past(ps, 8) |-> dev_d_oe == 8'h00)
        else $error("data pins driven in serial mode");
    a_desel_release:
        assert property (@(posedge link_clk) disable iff (!initialize_n)
        desel_cnt_ff >= 4'h8 |-> dev_d_oe == 8'h00)
        else $error("data pins driven while deselected");
    a_all_or_none:
        assert property (@(posedge link_clk) disable iff (!initialize_n)
        dev_d_oe != 8'h00 |-> dev_d_oe == 8'hff)
        else $error("partial data drive");
    a_drive_start_cause:
        assert property (@(posedge link_clk) disable iff (!initialize_n)
        $rose(dev_d_oe[0]) |-> ps && sel &&
        (style ? (rd_e && wr_rw) : !rd_e))
        else $error("drive began without a read phase");
    a_strobe_idle_quiet:
        assert property (@(posedge link_clk) disable iff (!initialize_n)
        !style && rd_e && $past(rd_e, 6) |-> dev_d_oe == 8'h00)
        else $error("drive held after read strobe rose");
    a_write_no_drive:
        assert property (@(posedge link_clk) disable iff (!initialize_n)
        style && !wr_rw && !$past(wr_rw, 6) |-> dev_d_oe == 8'h00)
        else $error("drive during write direction");
    a_strobe_selected:
        assert property (@(posedge clk) disable iff (!nrst)
        ps && !style && !(rd_e && wr_rw) |-> sel)
        else $error("strobe low while deselected");
    a_enable_selected:
        assert property (@(posedge clk) disable iff (!nrst)
        ps && style && rd_e |-> sel)
        else $error("enable high while deselected");
    a_ser_bit_stable:
        assert property (@(posedge clk) disable iff (!nrst)
        !ps && $rose(d_line[6]) |-> $stable(d_line[7]) && sel)
        else $error("serial data moved at clock rise");

    // Main traffic kinds seen at the pins
    c_serial_bit: cover property (@(posedge clk) disable iff (!nrst)
        !ps && $rose(d_line[6]));
    c_read_drive: cover property (@(posedge link_clk)
        disable iff (!initialize_n) $rose(dev_d_oe[0]));
    c_enable_pulse: cover property (@(posedge clk) disable iff (!nrst)
        ps && style && $rose(rd_e));
endmodule

// file: dv/lcd_host_bus_port_tb.sv
// Bench joining host and device ends of the LCD bus back to back.
// Assumes the package timing; link clock free running, unrelated phase.
`timescale 1ns/100ps
module lcd_host_bus_port_tb;
    import lcd_bus_pkg::*;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic nrst, par_mode, bus_style_select, reset_req, req_valid;
    logic req_ready, req_write, req_is_data, rsp_valid, got;
    logic rx_valid, rx_is_data, rd_done, serial_mode, ser_abort;
    logic [BUS_W-1:0] req_byte, rsp_byte, rd_data, status, rx_byte, rb;
    int n_mismatch = 0;
    int checks = 0;
    int n_rx = 0;
    int n_rd = 0;
    int n_abort = 0;

    lcd_bus_if lcd_bus_if_i ();
    lcd_host_port lcd_host_port_i (.clk(clk), .nrst(nrst),
        .bus(lcd_bus_if_i), .par_mode(par_mode),
        .bus_style_select(bus_style_select), .reset_req(reset_req),
        .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_is_data(req_is_data),
        .req_byte(req_byte), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte));
    lcd_dev_port lcd_dev_port_i (.link_clk(link_clk), .bus(lcd_bus_if_i),
        .rd_data(rd_data), .status(status), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_is_data(rx_is_data), .rd_done(rd_done),
        .serial_mode(serial_mode), .ser_abort(ser_abort));
    lcd_host_bus_port_sva lcd_host_bus_port_sva_i (.clk(clk), .nrst(nrst),
        .link_clk(link_clk), .initialize_n(lcd_bus_if_i.initialize_n),
        .ps(lcd_bus_if_i.ps), .style(lcd_bus_if_i.style),
        .chip_select_low(lcd_bus_if_i.chip_select_low),
        .chip_select_high(lcd_bus_if_i.chip_select_high),
        .rd_e(lcd_bus_if_i.rd_e), .wr_rw(lcd_bus_if_i.wr_rw),
        .d_line(lcd_bus_if_i.d_line),
        .dev_d_oe(lcd_bus_if_i.dev_d_oe));

    // Clocks; odd link edges (3, 9, 15 ns) never meet the clk edges
    always #10 clk = ~clk;
    always #3 link_clk = ~link_clk;
    // Count device pulses: bytes taken, read phases ended, bytes dropped
    always @(posedge link_clk)
    begin
        if (rx_valid === 1'b1)
            n_rx++;
        if (rd_done === 1'b1)
            n_rd++;
        if (ser_abort !== 1'b0)
            n_abort++;
    end

    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One request: valid held until the taking edge, then wait for idle
    task automatic req(input logic wr, input logic dc, input logic [7:0] b);
        int n;
        n = 0;
        got = 1'b0;
        rb = 'x;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_is_data <= dc;
        req_byte <= b;
        do @(negedge clk); while (req_ready !== 1'b1 && ++n < 400);
        @(posedge clk);
        req_valid <= 1'b0;
        do
        begin
            @(negedge clk);
            if (rsp_valid === 1'b1)
            begin
                got = 1'b1;
                rb = rsp_byte;
            end
        end
        while (req_ready !== 1'b1 && ++n < 400);
        if (n >= 400)
            n_mismatch++;
    endtask

    // Watchdog, several times the expected run
    initial
    begin
        #100000;
        n_mismatch++;
        finish_test();
    end

    initial
    begin
        nrst = 1'b0;
        par_mode = 1'b1;
        bus_style_select = 1'b0;
        reset_req = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_is_data = 1'b0;
        req_byte = 8'h00;
        rd_data = 8'h5a;
        status = 8'ha0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (40) @(posedge clk);
        // Strobe style, enable style, then serial: same traffic each
        for (int m = 0; m < 3; m++)
        begin
            par_mode <= (m != 2);
            bus_style_select <= (m == 1);
            repeat (20) @(posedge clk);
            check("serial_mode", {7'h00, serial_mode}, {7'h00, m == 2});
            req(1'b1, 1'b0, 8'h81);
            check("rx_byte", rx_byte, 8'h81);
            check("rx_is_data", {7'h00, rx_is_data}, 8'h00);
            req(1'b1, 1'b1, 8'h3c);
            check("rx_byte", rx_byte, 8'h3c);
            check("rx_is_data", {7'h00, rx_is_data}, 8'h01);
            req(1'b0, 1'b1, 8'h00);
            if (m == 2)
                check("serial rsp", {7'h00, got}, 8'h00);
            else
                check("data read", rb, rd_data);
            req(1'b0, 1'b0, 8'h00);
            if (m != 2)
                check("status read", rb, status);
        end
        check("rx count", 8'(n_rx), 8'h06);
        check("read ends", 8'(n_rd), 8'h04);
        check("dropped bytes", 8'(n_abort), 8'h00);
        // Reset level holds the device cleared while it stays low
        reset_req <= 1'b1;
        repeat (30) @(negedge clk);
        check("init pin", {7'h00, lcd_bus_if_i.initialize_n}, 8'h00);
        check("rx_byte in reset", rx_byte, 8'h00);
        check("ready in reset", {7'h00, req_ready}, 8'h00);
        @(posedge clk);
        reset_req <= 1'b0;
        par_mode <= 1'b1;
        repeat (40) @(posedge clk);
        req(1'b1, 1'b1, 8'h7e);
        check("rx_byte after reset", rx_byte, 8'h7e);
        finish_test();
    end
endmodule

// file: hw/lcd_bus_if.sv
// Pins between the host and the LCD module port.
// The shared data lines resolve here from the two enables; an undriven
// line reads high, as with a weak pull-up on the board.
`timescale 1ns/100ps
interface lcd_bus_if;
    logic ps;
    logic style;
    logic chip_select_low;
    logic chip_select_high;
    logic cmd_data_flag;
    logic rd_e;
    logic wr_rw;
    logic initialize_n;
    logic [7:0] host_d_out;
    logic [7:0] host_d_oe;
    logic [7:0] dev_d_out;
    logic [7:0] dev_d_oe;
    logic [7:0] d_line;

    // Per-line resolution, device wins whenever it drives, host otherwise
    for (genvar i = 0; i < 8; i++)
    begin : g_line
        assign d_line[i] = dev_d_oe[i] ? dev_d_out[i] :
                           host_d_oe[i] ? host_d_out[i] : 1'b1;
    end

    modport host (
        output ps,
        output style,
        output chip_select_low,
        output chip_select_high,
        output cmd_data_flag,
        output rd_e,
        output wr_rw,
        output initialize_n,
        output host_d_out,
        output host_d_oe,
        input d_line
    );

    modport device (
        input ps,
        input style,
        input chip_select_low,
        input chip_select_high,
        input cmd_data_flag,
        input rd_e,
        input wr_rw,
        input initialize_n,
        output dev_d_out,
        output dev_d_oe,
        input d_line
    );
endinterface

// file: hw/lcd_bus_pkg.sv
// Shared constants for the LCD module host bus port: pin reset levels,
// serial bit positions, host state codes and strobe timing in cycles.
// Assumes the host end runs on a 50 MHz clock.
package lcd_bus_pkg;

    // Bus geometry
    localparam int BUS_W = 8;
    localparam int SI_BIT = 7;
    localparam int SCL_BIT = 6;
    localparam int SER_BITS = 8;
    localparam int BITCNT_W = 4;

    // Control pin vector order: ps, style, csl, csh, dc, rd_e, wr_rw
    localparam int CTL_W = 7;
    localparam int C_PS = 6;
    localparam int C_STYLE = 5;
    localparam int C_CSL = 4;
    localparam int C_CSH = 3;
    localparam int C_DC = 2;
    localparam int C_RDE = 1;
    localparam int C_WRRW = 0;
    localparam logic [CTL_W-1:0] CTL_RST = 7'h53;
    localparam logic [BUS_W-1:0] DATA_RST = 8'h00;

    // Host clock and documented least times in ns
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_SETUP_NS = 20;
    localparam int T_LOW_WR_NS = 60;
    localparam int T_LOW_RD_NS = 120;
    localparam int T_HIGH_NS = 60;
    localparam int T_CYCLE_NS = 300;
    localparam int T_SCL_HALF_NS = 125;
    localparam int T_CS_SCL_NS = 150;

    // Least times rounded up to whole host cycles
    localparam int SETUP_CYC =
        (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_WR_CYC =
        (T_LOW_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_RD_CYC =
        (T_LOW_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIGH_CYC = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYCLE_CYC =
        (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCL_HALF_CYC =
        (T_SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_SCL_CYC =
        (T_CS_SCL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 5;

    // Host sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SETUP = 6'h02,
        ST_ACT = 6'h04,
        ST_RECOV = 6'h08,
        ST_SLO = 6'h10,
        ST_SHI = 6'h20
    } host_state_t;

endpackage

// file: hw/lcd_dev_port.sv
// Device end of the LCD module host bus: parallel (two strobe styles)
// and write-only serial reception, read drive-back and pin tri-state.
// Assumes link_clk is much faster than any host strobe phase, so every
// strobe level is seen for several cycles after synchronisation.
`timescale 1ns/100ps
module lcd_dev_port (
    input wire logic link_clk,
    lcd_bus_if.device bus,
    input wire logic [lcd_bus_pkg::BUS_W-1:0] rd_data,
    input wire logic [lcd_bus_pkg::BUS_W-1:0] status,
    output logic rx_valid,
    output logic [lcd_bus_pkg::BUS_W-1:0] rx_byte,
    output logic rx_is_data,
    output logic rd_done,
    output logic serial_mode,
    output logic ser_abort
);
    import lcd_bus_pkg::*;

    logic rst_a_ff;
    logic rst_b_ff;
    logic [CTL_W-1:0] ctl_s;
    logic [BUS_W-1:0] dat_s;
    logic sel;
    logic par;
    logic enable_style;
    logic rd_act;
    logic rd_prev_ff;
    logic wr_prev_ff;
    logic e_prev_ff;
    logic scl_prev_ff;
    logic par_wr;
    logic scl_rise;
    logic [BUS_W-2:0] shift_ff;
    logic [BITCNT_W-1:0] bitcnt_ff;
    logic ser_last;
    logic [BUS_W-1:0] dout_ff;
    logic [BUS_W-1:0] doe_ff;
    logic rx_valid_ff;
    logic [BUS_W-1:0] rx_byte_ff;
    logic rx_is_data_ff;
    logic rd_done_ff;
    logic serial_mode_ff;
    logic ser_abort_ff;

    // Reset follows the pin level; release is synchronised so no flop
    // leaves reset on a different edge from its neighbours.
    always_ff @(posedge link_clk or negedge bus.initialize_n)
    begin
        if (!bus.initialize_n)
        begin
            rst_a_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end
        else
        begin
            rst_a_ff <= 1'b1;
            rst_b_ff <= rst_a_ff;
        end
    end

    // Control pins into the link domain
    pin_sync3 #(
        .W(CTL_W),
        .RST_VAL(CTL_RST)
    ) u_ctl_sync (
        .clk(link_clk),
        .rst_n(rst_b_ff),
        .din({bus.ps, bus.style, bus.chip_select_low,
              bus.chip_select_high, bus.cmd_data_flag, bus.rd_e,
              bus.wr_rw}),
        .dout(ctl_s)
    );

    // Data pins into the link domain; same latency as the strobes
    pin_sync3 #(
        .W(BUS_W),
        .RST_VAL(DATA_RST)
    ) u_dat_sync (
        .clk(link_clk),
        .rst_n(rst_b_ff),
        .din(bus.d_line),
        .dout(dat_s)
    );

    // Mode and selection decode
    assign sel = ~ctl_s[C_CSL] & ctl_s[C_CSH];
    assign par = ctl_s[C_PS];
    assign enable_style = ctl_s[C_STYLE];

    // Read phase: enable high with direction high, or read strobe low
    assign rd_act = sel & par & (enable_style ?
                    (ctl_s[C_RDE] & ctl_s[C_WRRW]) :
                    ~ctl_s[C_RDE]);

    // Parallel write: write strobe rising, or enable falling in a write
    assign par_wr = sel & par & (enable_style ?
                    (e_prev_ff & ~ctl_s[C_RDE] & ~ctl_s[C_WRRW]) :
                    (~wr_prev_ff & ctl_s[C_WRRW]));

    // Serial clock on bit 6, sampled only while selected in serial mode
    assign scl_rise = sel & ~par & dat_s[SCL_BIT] & ~scl_prev_ff;
    assign ser_last = scl_rise &&
                      (bitcnt_ff == BITCNT_W'(SER_BITS - 1));

    // Previous strobe levels for edge detection
    always_ff @(posedge link_clk or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
        begin
            rd_prev_ff <= 1'b0;
            wr_prev_ff <= 1'b1;
            e_prev_ff <= 1'b0;
            scl_prev_ff <= 1'b0;
        end
        else
        begin
            rd_prev_ff <= rd_act;
            wr_prev_ff <= ctl_s[C_WRRW];
            e_prev_ff <= ctl_s[C_RDE];
            scl_prev_ff <= dat_s[SCL_BIT];
        end
    end

    // Serial shift register, MSB arrives first
    always_ff @(posedge link_clk or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
            shift_ff <= '0;
        else if (scl_rise)
            shift_ff <= {shift_ff[BUS_W-3:0], dat_s[SI_BIT]};
    end

    // Bit counter restarts whenever the frame is broken by deselection
    // or a mode change, so a stray clock cannot misalign later bytes.
    always_ff @(posedge link_clk or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
            bitcnt_ff <= '0;
        else if (!sel || par)
            bitcnt_ff <= '0;
        else if (ser_last)
            bitcnt_ff <= '0;
        else if (scl_rise)
            bitcnt_ff <= bitcnt_ff + BITCNT_W'(1);
    end

    // Partial serial byte thrown away by deselection
    always_ff @(posedge link_clk or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
            ser_abort_ff <= 1'b0;
        else
            ser_abort_ff <= (!sel || par) && (bitcnt_ff != '0);
    end

    // Received byte with its data/command routing flag
    always_ff @(posedge link_clk or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
        begin
            rx_valid_ff <= 1'b0;
            rx_byte_ff <= '0;
            rx_is_data_ff <= 1'b0;
        end
        else
        begin
            rx_valid_ff <= par_wr | ser_last;
            if (par_wr)
            begin
                rx_byte_ff <= dat_s;
                rx_is_data_ff <= ctl_s[C_DC];
            end
            else if (ser_last)
            begin
                rx_byte_ff <= {shift_ff, dat_s[SI_BIT]};
                rx_is_data_ff <= ctl_s[C_DC];
            end
        end
    end

    // Read drive-back: flag picks display data or status. Only the
    // parallel read phase enables the pins, so serial mode and a
    // deselected port never drive any line.
    always_ff @(posedge link_clk or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
        begin
            dout_ff <= '0;
            doe_ff <= '0;
        end
        else
        begin
            dout_ff <= ctl_s[C_DC] ? rd_data : status;
            doe_ff <= {BUS_W{rd_act}};
        end
    end

    // End of a read phase lets the user side advance its read pointer
    always_ff @(posedge link_clk or negedge rst_b_ff)
    begin
        if (!rst_b_ff)
        begin
            rd_done_ff <= 1'b0;
            serial_mode_ff <= 1'b0;
        end
        else
        begin
            rd_done_ff <= rd_prev_ff & ~rd_act;
            serial_mode_ff <= ~par;
        end
    end

    assign bus.dev_d_out = dout_ff;
    assign bus.dev_d_oe = doe_ff;
    assign rx_valid = rx_valid_ff;
    assign rx_byte = rx_byte_ff;
    assign rx_is_data = rx_is_data_ff;
    assign rd_done = rd_done_ff;
    assign serial_mode = serial_mode_ff;
    assign ser_abort = ser_abort_ff;
endmodule

// file: hw/lcd_host_port.sv
// Host end of the LCD module bus: turns byte requests into parallel
// strobe cycles or serial frames with timing met on the 50 MHz clock.
// Assumes user requests and strap choices come from logic on clk.
`timescale 1ns/100ps
module lcd_host_port (
    input wire logic clk,
    input wire logic nrst,
    lcd_bus_if.host bus,
    input wire logic par_mode,
    input wire logic bus_style_select,
    input wire logic reset_req,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_is_data,
    input wire logic [lcd_bus_pkg::BUS_W-1:0] req_byte,
    output logic rsp_valid,
    output logic [lcd_bus_pkg::BUS_W-1:0] rsp_byte
);
    import lcd_bus_pkg::*;

    host_state_t state_ff;
    host_state_t nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [BITCNT_W-1:0] bit_ff;
    logic [BUS_W-1:0] sh_ff;
    logic wr_ff;
    logic dc_ff;
    logic ps_ff;
    logic style_ff;
    logic init_n_ff;
    logic [BUS_W-1:0] din_s;
    logic accept;
    logic cnt_done;
    logic rsp_valid_ff;
    logic [BUS_W-1:0] rsp_byte_ff;

    // Read data pins come from the other party's clock domain
    pin_sync3 #(
        .W(BUS_W),
        .RST_VAL(DATA_RST)
    ) u_din_sync (
        .clk(clk),
        .rst_n(nrst),
        .din(bus.d_line),
        .dout(din_s)
    );

    // Serial reads are taken and dropped: that link has no return path
    assign req_ready = (state_ff == ST_IDLE) && init_n_ff;
    assign accept = req_valid && req_ready;
    assign cnt_done = (cnt_ff == CNT_W'(1));

    // Sequencer
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff - CNT_W'(1);
        case (state_ff)
            ST_IDLE:
            begin
                nxt_cnt = CNT_W'(SETUP_CYC);
                if (accept && (ps_ff || req_write))
                begin
                    nxt_state = ST_SETUP;
                    if (!ps_ff)
                        nxt_cnt = CNT_W'(CS_SCL_CYC);
                end
            end
            ST_SETUP:
                if (cnt_done)
                begin
                    nxt_state = ps_ff ? ST_ACT : ST_SLO;
                    nxt_cnt = ps_ff ? (wr_ff ? CNT_W'(LOW_WR_CYC) :
                              CNT_W'(LOW_RD_CYC)) : CNT_W'(SCL_HALF_CYC);
                end
            ST_ACT:
                if (cnt_done)
                begin
                    nxt_state = ST_RECOV;
                    nxt_cnt = wr_ff ? CNT_W'(CYCLE_CYC - LOW_WR_CYC) :
                              CNT_W'(CYCLE_CYC - LOW_RD_CYC);
                end
            ST_SLO:
                if (cnt_done)
                begin
                    nxt_state = ST_SHI;
                    nxt_cnt = CNT_W'(SCL_HALF_CYC);
                end
            ST_SHI:
                if (cnt_done)
                begin
                    nxt_state = (bit_ff == BITCNT_W'(SER_BITS - 1)) ?
                                ST_RECOV : ST_SLO;
                    nxt_cnt = (bit_ff == BITCNT_W'(SER_BITS - 1)) ?
                              CNT_W'(CS_SCL_CYC) : CNT_W'(SCL_HALF_CYC);
                end
            ST_RECOV:
                if (cnt_done)
                    nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Request capture and serial shifting, MSB first
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ff <= 1'b1;
            dc_ff <= 1'b0;
            sh_ff <= '0;
            bit_ff <= '0;
        end
        else if (accept)
        begin
            wr_ff <= req_write;
            dc_ff <= req_is_data;
            sh_ff <= req_byte;
            bit_ff <= '0;
        end
        else if (state_ff == ST_SHI && cnt_done)
        begin
            sh_ff <= {sh_ff[BUS_W-2:0], 1'b0};
            bit_ff <= bit_ff + BITCNT_W'(1);
        end
    end

    // Straps only change between transfers; reset line held from reset
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ps_ff <= 1'b1;
            style_ff <= 1'b0;
            init_n_ff <= 1'b0;
        end
        else
        begin
            init_n_ff <= ~reset_req;
            if (state_ff == ST_IDLE && !accept)
            begin
                ps_ff <= par_mode;
                style_ff <= bus_style_select;
            end
        end
    end

    // Read data taken on the last cycle of the strobe phase
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rsp_valid_ff <= 1'b0;
            rsp_byte_ff <= '0;
        end
        else
        begin
            rsp_valid_ff <= (state_ff == ST_ACT) && cnt_done && !wr_ff;
            if ((state_ff == ST_ACT) && cnt_done && !wr_ff)
                rsp_byte_ff <= din_s;
        end
    end

    // Pin levels. Chip select is held from setup through recovery.
    assign bus.ps = ps_ff;
    assign bus.style = style_ff;
    assign bus.initialize_n = init_n_ff;
    assign bus.chip_select_low = (state_ff == ST_IDLE);
    assign bus.chip_select_high = (state_ff != ST_IDLE);
    assign bus.cmd_data_flag = dc_ff;
    assign bus.rd_e = style_ff ? (state_ff == ST_ACT) :
                      !((state_ff == ST_ACT) && !wr_ff);
    assign bus.wr_rw = style_ff ? !wr_ff :
                       !((state_ff == ST_ACT) && wr_ff);
    assign bus.host_d_out = ps_ff ? sh_ff :
        {sh_ff[BUS_W-1], (state_ff != ST_SLO), {(BUS_W-2){1'b0}}};
    assign bus.host_d_oe = ps_ff ? {BUS_W{(state_ff != ST_IDLE) && wr_ff}} :
        {2'b11, {(BUS_W-2){1'b0}}};
    assign rsp_valid = rsp_valid_ff;
    assign rsp_byte = rsp_byte_ff;
endmodule

// file: hw/pin_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk; output moves only when the
// second and third stages agree, so one-cycle glitches are dropped.
`timescale 1ns/100ps
module pin_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;

    // Refuse a zero-width instance at elaboration
    if (W < 1)
    begin : g_bad_width
        $error("pin_sync3: W must be at least 1");
    end

    // Stage chain; first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
        end
        else
        begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Per-bit agreement filter
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                out_ff[i] <= RST_VAL[i];
            else if (s2_ff[i] == s3_ff[i])
                out_ff[i] <= s3_ff[i];
        end
    end

    assign dout = out_ff;
endmodule
